//--- verilog/sleep_defines.svh
// Constants for the sleep state controller.
`ifndef SLEEP_DEFINES_SVH
`define SLEEP_DEFINES_SVH

`define SELECT_MSB 1
`define SELECT_LSB 0
`define SELECT_ACTIVE 2'h0
`define SELECT_LIGHT 2'h1
`define SELECT_DEEP 2'h2
`define SELECT_DEEPEST 2'h3

`define CLOCK_MHZ 25
`define SETTLE_NS 2000
`define SETTLE_CYCLES ((`SETTLE_NS * `CLOCK_MHZ + 999) / 1000)
`define SETTLE_WIDTH 8

`endif

//--- verilog/sleep_pkg.sv
// Types shared by the sleep state controller.
`default_nettype none
package sleep_pkg;

    typedef enum logic [4:0]
    {
        ACTIVE_STATE = 5'h01,
        LIGHT_SLEEP_STATE = 5'h02,
        DEEP_SLEEP_STATE = 5'h04,
        DEEPEST_SLEEP_STATE = 5'h08,
        SETTLE_STATE = 5'h10
    } power_state_type;

    typedef struct packed
    {
        logic regulator_on;
        logic core_clock_on;
        logic sleeping;
        logic config_lost;
        logic [1:0] sleep_state_select;
    } power_status_type;

endpackage : sleep_pkg

`default_nettype wire

//--- verilog/wake_sync.sv
// Three-stage synchroniser for the external wake-up pin.
`timescale 1ns/1ps
`default_nettype none

module wake_sync
(
    input wire logic clock,
    input wire logic reset,
    input wire logic pin,
    output var logic level
);

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic level_reg;
    wire agree = (stage2_reg == stage3_reg);

    // A change is taken only once the second and third stages agree.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            stage1_reg <= 1'h0;
            stage2_reg <= 1'h0;
            stage3_reg <= 1'h0;
            level_reg <= 1'h0;
        end
        else
        begin
            stage1_reg <= pin;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            if (agree)
            begin
                level_reg <= stage3_reg;
            end
        end
    end

    assign level = level_reg;

endmodule : wake_sync

`default_nettype wire

//--- verilog/sleep_control.sv
// Sleep state controller: mode selection, entry, wake-up and regulator.
//
// Contract
// - There is an active state and three sleep states, chosen by a two-bit field whose zero means stay active.
// - The select field in bits one down to zero decides which sleep state a trigger enters.
// - A sleep state begins only after software sets the entry trigger.
// - Light and deep sleep wake on reset, sleep timer or external interrupt; the regulator stays on in light and goes off in deep.
`timescale 1ns/1ps
`default_nettype none
`include "sleep_defines.svh"

module sleep_control
    import sleep_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [1:0] sleep_control_register,
    input wire logic sleep_entry_trigger,
    input wire logic sleep_timer_irq,
    input wire logic ext_irq_pin,
    input wire logic config_restored,
    output var power_status_type status,
    output var logic wake_event
);

    localparam logic [`SETTLE_WIDTH-1:0] settle_last =
        `SETTLE_WIDTH'(`SETTLE_CYCLES - 1);

    power_state_type state_reg;
    power_state_type state_next;
    logic [`SETTLE_WIDTH-1:0] settle_reg;
    logic [`SETTLE_WIDTH-1:0] settle_next;
    power_status_type status_reg;
    power_status_type status_next;
    logic wake_event_reg;
    logic config_lost_reg;
    logic ext_wake;

    wake_sync ext_sync
    (
        .clock(clock),
        .reset(reset),
        .pin(ext_irq_pin),
        .level(ext_wake)
    );

    wire [1:0] sleep_state_select =
        sleep_control_register[`SELECT_MSB:`SELECT_LSB];
    wire select_sleep = (sleep_state_select != `SELECT_ACTIVE);
    wire entry_taken = (state_reg == ACTIVE_STATE) && sleep_entry_trigger
        && select_sleep;
    wire timed_wake = sleep_timer_irq || ext_wake;
    wire settle_done = (settle_reg == settle_last);
    wire leaving_sleep = (state_reg != ACTIVE_STATE)
        && (state_reg != SETTLE_STATE) && (state_next != state_reg);
    wire regulator_off_next = (state_next == DEEP_SLEEP_STATE)
        || (state_next == DEEPEST_SLEEP_STATE);
    wire regulator_off_now = (state_reg == DEEP_SLEEP_STATE)
        || (state_reg == DEEPEST_SLEEP_STATE);
    wire entering_unkept = regulator_off_next && !regulator_off_now;

    // Next state selection.
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ACTIVE_STATE:
            begin
                if (entry_taken)
                begin
                    unique case (sleep_state_select)
                        `SELECT_LIGHT: state_next = LIGHT_SLEEP_STATE;
                        `SELECT_DEEP: state_next = DEEP_SLEEP_STATE;
                        `SELECT_DEEPEST: state_next = DEEPEST_SLEEP_STATE;
                        default: state_next = ACTIVE_STATE;
                    endcase
                end
            end
            LIGHT_SLEEP_STATE:
            begin
                if (timed_wake)
                begin
                    state_next = ACTIVE_STATE;
                end
            end
            DEEP_SLEEP_STATE:
            begin
                if (timed_wake)
                begin
                    state_next = SETTLE_STATE;
                end
            end
            DEEPEST_SLEEP_STATE:
            begin
                if (ext_wake)
                begin
                    state_next = SETTLE_STATE;
                end
            end
            SETTLE_STATE:
            begin
                if (settle_done)
                begin
                    state_next = ACTIVE_STATE;
                end
            end
        endcase
    end

    assign settle_next = (state_reg == SETTLE_STATE) && !settle_done
        ? settle_reg + `SETTLE_WIDTH'(1) : `SETTLE_WIDTH'(0);

    // The loss flag is set on entry to an unpowered state; set beats clear.
    wire config_lost_next = entering_unkept
        || (config_lost_reg && !config_restored);

    always_comb
    begin
        status_next.regulator_on = !regulator_off_next;
        status_next.core_clock_on = (state_next == ACTIVE_STATE);
        status_next.sleeping = (state_next != ACTIVE_STATE);
        status_next.config_lost = config_lost_next;
        status_next.sleep_state_select = sleep_state_select;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_reg <= ACTIVE_STATE;
            settle_reg <= `SETTLE_WIDTH'(0);
            config_lost_reg <= 1'h0;
            wake_event_reg <= 1'h0;
            status_reg <= '{1'h1, 1'h1, 1'h0, 1'h0, 2'h0};
        end
        else
        begin
            state_reg <= state_next;
            settle_reg <= settle_next;
            config_lost_reg <= config_lost_next;
            wake_event_reg <= leaving_sleep;
            status_reg <= status_next;
        end
    end

    assign status = status_reg;
    assign wake_event = wake_event_reg;

    default clocking main_clk @(posedge clock);
    endclocking
    default disable iff (reset);

    localparam int settle_max = 60;
    localparam int settle_len = `SETTLE_CYCLES;

    mode_zero_stays_a: assert property (
        (state_reg == ACTIVE_STATE) && sleep_entry_trigger
        && (sleep_control_register == 2'h0) |=> state_reg == ACTIVE_STATE)
        else $error("Zero select left the active state.");

    select_maps_state_a: assert property (
        entry_taken |=> state_reg == ($past(sleep_control_register) == 2'h1
        ? LIGHT_SLEEP_STATE : $past(sleep_control_register) == 2'h2
        ? DEEP_SLEEP_STATE : DEEPEST_SLEEP_STATE))
        else $error("Sleep state differs from the selected one.");

    entry_needs_trigger_a: assert property (
        (state_reg == ACTIVE_STATE) && !sleep_entry_trigger
        |=> state_reg == ACTIVE_STATE)
        else $error("Sleep began without the trigger.");

    light_wake_regulator_a: assert property (
        (state_reg == LIGHT_SLEEP_STATE) && sleep_timer_irq
        |-> status.regulator_on ##1 (state_reg == ACTIVE_STATE)
        && wake_event)
        else $error("Light sleep wake-up went wrong.");

    deep_wake_bounded_a: assert property (
        (state_reg == DEEP_SLEEP_STATE) && !status.regulator_on
        && sleep_timer_irq |=> ##[1:settle_max] state_reg == ACTIVE_STATE)
        else $error("Deep sleep failed to wake in time.");

    config_lost_flag_a: assert property (
        $rose(state_reg == DEEP_SLEEP_STATE) |-> status.config_lost)
        else $error("Loss of configuration was not flagged.");

    deepest_lost_flag_a: assert property (
        $rose(state_reg == DEEPEST_SLEEP_STATE) |-> status.config_lost)
        else $error("Deepest sleep did not flag the lost configuration.");

    light_keeps_regulator_a: assert property (
        (state_reg == LIGHT_SLEEP_STATE)
        |-> status.regulator_on && status.sleeping)
        else $error("Regulator went off in light sleep.");

    deep_regulator_off_a: assert property (
        (state_reg == DEEP_SLEEP_STATE)
        |-> !status.regulator_on && !status.core_clock_on)
        else $error("Regulator stayed on in deep sleep.");

    deepest_ignores_timer_a: assert property (
        (state_reg == DEEPEST_SLEEP_STATE) && !ext_wake
        |=> state_reg == DEEPEST_SLEEP_STATE)
        else $error("Deepest sleep left without the pin wake.");

    settle_length_a: assert property (
        $rose(state_reg == SETTLE_STATE)
        |-> ##settle_len state_reg == ACTIVE_STATE)
        else $error("Regulator settling took the wrong time.");

    settle_regulator_on_a: assert property (
        (state_reg == SETTLE_STATE)
        |-> status.regulator_on && status.sleeping)
        else $error("Settling phase lost the regulator.");

    wake_pulse_single_a: assert property (
        wake_event |=> !wake_event)
        else $error("Wake pulse lasted more than one cycle.");

    select_copied_a: assert property (
        !$past(reset)
        |-> status.sleep_state_select == $past(sleep_control_register))
        else $error("Shown select differs from the input.");

endmodule : sleep_control

`default_nettype wire

//--- bench/tb_sleep_control.sv
// Self-checking testbench for the sleep state controller.
`timescale 1ns/1ps
`default_nettype none
`include "sleep_defines.svh"

module tb_sleep_control;
    import sleep_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [1:0] sel_in = 2'h0;
    logic trig = 1'b0;
    logic timer = 1'b0;
    logic ext = 1'b0;
    logic restored = 1'b0;
    power_status_type status;
    logic wake_event;
    integer err_total = 0;
    integer num_checks = 0;
    integer seed = 32'h3D5C1057;
    integer i;
    integer n;
    integer k;
    logic [1:0] sel;

    sleep_control sleep_control_inst
    (
        .clock(clock),
        .reset(reset),
        .sleep_control_register(sel_in),
        .sleep_entry_trigger(trig),
        .sleep_timer_irq(timer),
        .ext_irq_pin(ext),
        .config_restored(restored),
        .status(status),
        .wake_event(wake_event)
    );

    always #20 clock = ~clock;

    task check(input logic [5:0] seen, input logic [5:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task end_sim;
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    function automatic logic [5:0] asleep(input logic [1:0] s);
        return {s == `SELECT_LIGHT, 1'b0, 1'b1, s != `SELECT_LIGHT, s};
    endfunction : asleep

    function automatic logic [5:0] awake(input logic lost,
        input logic [1:0] s);
        return {1'b1, 1'b1, 1'b0, lost, s};
    endfunction : awake

    task enter(input logic [1:0] s);
        @(posedge clock);
        sel_in <= s;
        trig <= 1'b1;
        @(posedge clock);
        trig <= 1'b0;
        @(negedge clock);
    endtask : enter

    initial
    begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        check(status, awake(1'b0, 2'h0));
        check(wake_event, 1'b0);
        enter(`SELECT_ACTIVE);
        check(status, awake(1'b0, 2'h0));
        @(posedge clock);
        sel_in <= `SELECT_DEEP;
        repeat (4) @(posedge clock);
        @(negedge clock);
        check(status, awake(1'b0, `SELECT_DEEP));
        for (i = 0; i < 9; i = i + 1)
        begin
            n = $random(seed);
            sel = (i < 3) ? 2'(i + 1) : 2'(n[7:0] % 3 + 1);
            enter(sel);
            check(status, asleep(sel));
            if (sel == `SELECT_DEEPEST)
            begin
                @(posedge clock);
                timer <= 1'b1;
                repeat (5) @(posedge clock);
                timer <= 1'b0;
                @(negedge clock);
                check(status, asleep(sel));
            end
            @(posedge clock);
            if (sel == `SELECT_DEEPEST || n[8])
                ext <= 1'b1;
            else
                timer <= 1'b1;
            k = 0;
            do
            begin
                @(negedge clock);
                k = k + 1;
            end
            while (wake_event !== 1'b1 && k < 10);
            check(wake_event, 1'b1);
            if (sel == `SELECT_LIGHT)
                check(status, awake(1'b0, sel));
            else
                check(status, {4'hB, sel});
            @(posedge clock);
            timer <= 1'b0;
            ext <= 1'b0;
            if (sel == `SELECT_LIGHT)
            begin
                @(negedge clock);
                check(wake_event, 1'b0);
                repeat (4) @(posedge clock);
            end
            else
            begin
                repeat (`SETTLE_CYCLES - 2) @(posedge clock);
                @(negedge clock);
                check(status, {4'hB, sel});
                @(negedge clock);
                check(status, awake(1'b1, sel));
                @(posedge clock);
                restored <= 1'b1;
                @(posedge clock);
                restored <= 1'b0;
                @(negedge clock);
                check(status, awake(1'b0, sel));
            end
        end
        enter(`SELECT_DEEP);
        check(status, asleep(`SELECT_DEEP));
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        check(status, awake(1'b0, 2'h0));
        @(negedge clock);
        check(status, awake(1'b0, `SELECT_DEEP));
        check(wake_event, 1'b0);
        end_sim;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        err_total = err_total + 1;
        end_sim;
    end

endmodule : tb_sleep_control
`default_nettype wire
